// file: core/ssf_pkg.sv
/*
 * Types shared by the serial status flag block and its surroundings.
 * Assumes the shifters run on the same clock as the register bus.
 */
package ssf_pkg;

    // one received character, valid for a single cycle
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       par;
        logic       mp;
        logic       stop;
    } ssf_rx_evt_t;

    // what the transmit shifter is offered
    typedef struct packed {
        logic       go;
        logic [7:0] data;
        logic       mp_en;
        logic       mp;
    } ssf_tx_req_t;

endpackage

// file: core/ssf_regs.svh
/*
 * Register offsets, bit positions and reset values of the serial status
 * flag block. Assumes a byte-addressed APB with one 32-bit word per register.
 */
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// register offsets (byte addresses)
`define SSF_OFS_STATUS  8'h00
`define SSF_OFS_CTRL    8'h04
`define SSF_OFS_FORMAT  8'h08
`define SSF_OFS_TXBUF   8'h0c
`define SSF_OFS_RXBUF   8'h10

// status register bits
`define SSF_B_TX_BUFFER_EMPTY      7
`define SSF_B_RX_BUFFER_FULL      6
`define SSF_B_OVERRUN_FLAG      5
`define SSF_B_FER       4
`define SSF_B_PER       3
`define SSF_B_TX_DONE      2
`define SSF_B_RXADDR    1
`define SSF_B_TXADDR    0
`define SSF_B_HWFLAG_LO 2
`define SSF_STATUS_RST  8'h84
`define SSF_CLR_MASK    8'hf8

// control register bits
`define SSF_C_TX_ON     0
`define SSF_C_RX_ON     1
`define SSF_C_RXIRQ_ON  2
`define SSF_C_TXFIN_ON  3
`define SSF_CTRL_RST    8'h00

// format register bits
`define SSF_F_SYNC      0
`define SSF_F_PAR_EN    1
`define SSF_F_ODD       2
`define SSF_F_MP        3
`define SSF_F_STOP2     4
`define SSF_F_CHR7      5
`define SSF_FORMAT_RST  8'h00

`define SSF_BUF_RST     8'h00
`define SSF_RDATA_PAD   24'h000000

`endif

// file: core/ssf_status.sv
/*
 * Status flag logic of a serial port: transmit/receive buffer flags, error
 * flags, transmit end and multiprocessor bits, with an APB register slave.
 * Assumes shifters, DMA strobes and standby are synchronous to pclk, and that
 * the transmit shifter pulses tx_load only while tx_req.go is high.
 */
// Contract
// RULE_01: writing 1 to clearable flags does nothing; 0 clears only after read as 1
// RULE_02: reset or standby forces status to 84 hex
// RULE_03: transmit-done and received address bit ignore cpu writes
// RULE_04: transmit-empty sets on reset, standby, transmit off, buffer to shifter
// RULE_05: transmit-empty clears by read-1-write-0 or dma buffer write
// RULE_06: receive-full sets when a clean character reaches the receive buffer
// RULE_07: receive-full clears on reset, standby, read-1-write-0, dma buffer read
// RULE_08: receive errors or receiver off leave buffer and receive-full alone
// RULE_09: character completing while receive-full set raises overrun, is discarded
// RULE_10: any error flag stops reception; synchronous mode also stops transmission
// RULE_11: asynchronous zero stop bit raises the framing flag
// RULE_12: with two stop bits only the first is checked
// RULE_13: framing error still loads the buffer but not receive-full
// RULE_14: asynchronous parity mismatch raises the parity flag
// RULE_15: parity error still loads the buffer but not receive-full
// RULE_16: receiver off keeps overrun, framing and parity flags
// RULE_17: transmit-done sets on reset, standby, transmit off, last bit when empty
// RULE_18: transmit-done clears with transmit-empty sequence or dma buffer write
// RULE_19: received address bit captured in asynchronous multiprocessor format only
// RULE_20: transmit address bit used only in asynchronous multiprocessor transmission
// RULE_21: receive interrupt enable gates full and error requests
// RULE_22: transmit-end enable gates request while transmit-done set
// RULE_23: per-flag read-as-one record gates each zero-write clear
`include "ssf_regs.svh"

module ssf_status
    import ssf_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // system
    input  wire logic         standby,
    // transmit shifter
    input  wire logic         tx_load,
    input  wire logic         tx_last_bit,
    output ssf_tx_req_t       tx_req,
    // receive shifter
    input  wire ssf_rx_evt_t  rx_evt,
    output logic              rx_accept,
    // dma controller
    input  wire logic         dma_tx_write,
    input  wire logic [7:0]   dma_tx_data,
    input  wire logic         dma_rx_read,
    output logic [7:0]        rx_data,
    // interrupt requests
    output logic              rx_full_irq,
    output logic              rx_error_irq,
    output logic              tx_finish_irq
);

////////////////////////////////////////////////////////////////////////////////

    logic [7:0] serial_flags_reg;
    logic [7:0] serial_ctrl_reg;
    logic [7:0] serial_format_reg;
    logic [7:0] tx_buffer;
    logic [7:0] rx_buffer;
    logic [7:0] read_seen;
    logic [7:0] next_flags;
    logic [7:0] next_seen;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] sw_clr;
    logic [7:0] read_mux;
    logic       acc;
    logic       wr;
    logic       rd_setup;
    logic       wr_status;
    logic       rd_status;
    logic       tx_on;
    logic       async_mode;
    logic       err_any;
    logic       rx_take;
    logic       fer_raw;
    logic       per_raw;
    logic       good_ev;
    logic       ovr_ev;

    localparam logic [7:0] clr_mask = `SSF_CLR_MASK;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `SSF_OFS_STATUS) || (a == `SSF_OFS_CTRL) ||
                  (a == `SSF_OFS_FORMAT) || (a == `SSF_OFS_TXBUF) ||
                  (a == `SSF_OFS_RXBUF);
    endfunction

    // seven-bit characters leave bit 7 out of the count
    function automatic logic parity_bad(input logic [7:0] d, input logic p,
                                        input logic odd, input logic chr7);
        logic [7:0] m;
        m = d;
        if (chr7) begin
            m[7] = 1'b0;
        end
        parity_bad = (^m) ^ p ^ odd;
    endfunction

////////////////////////////////////////////////////////////////////////////////
// bus decode

    assign acc       = psel & penable;
    assign wr        = acc & pwrite & addr_ok(paddr);
    assign rd_setup  = psel & ~penable & ~pwrite;
    assign wr_status = wr & (paddr == `SSF_OFS_STATUS);
    assign rd_status = acc & ~pwrite & (paddr == `SSF_OFS_STATUS);
    assign pready    = 1'b1;
    assign pslverr   = acc & ~addr_ok(paddr);

    always_comb begin
        case (paddr)
            `SSF_OFS_STATUS: read_mux = serial_flags_reg;
            `SSF_OFS_CTRL:   read_mux = serial_ctrl_reg;
            `SSF_OFS_FORMAT: read_mux = serial_format_reg;
            `SSF_OFS_TXBUF:  read_mux = tx_buffer;
            `SSF_OFS_RXBUF:  read_mux = rx_buffer;
            default:         read_mux = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= {`SSF_RDATA_PAD, read_mux};
        end
    end

////////////////////////////////////////////////////////////////////////////////
// control, format and data registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_ctrl_reg   <= `SSF_CTRL_RST;
            serial_format_reg <= `SSF_FORMAT_RST;
        end else if (wr) begin
            if (paddr == `SSF_OFS_CTRL) begin
                serial_ctrl_reg <= pwdata[7:0];
            end
            if (paddr == `SSF_OFS_FORMAT) begin
                serial_format_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer <= `SSF_BUF_RST;
        end else if (dma_tx_write) begin
            tx_buffer <= dma_tx_data;
        end else if (wr && paddr == `SSF_OFS_TXBUF) begin
            tx_buffer <= pwdata[7:0];
        end
    end

    assign tx_on      = serial_ctrl_reg[`SSF_C_TX_ON];
    assign async_mode = ~serial_format_reg[`SSF_F_SYNC];
    assign err_any    = serial_flags_reg[`SSF_B_OVERRUN_FLAG] | serial_flags_reg[`SSF_B_FER] |
                        serial_flags_reg[`SSF_B_PER];

////////////////////////////////////////////////////////////////////////////////
// receive path

    // RULE_10: errors block rx
    assign rx_accept = serial_ctrl_reg[`SSF_C_RX_ON] & ~err_any;
    assign rx_take   = rx_evt.valid & rx_accept;

    // RULE_11: stop bit check
    // RULE_12: only first stop bit arrives here, the second is never looked at
    assign fer_raw = async_mode & ~rx_evt.stop;
    // RULE_14: parity check
    assign per_raw = async_mode & serial_format_reg[`SSF_F_PAR_EN] &
                     parity_bad(rx_evt.data, rx_evt.par, serial_format_reg[`SSF_F_ODD],
                                serial_format_reg[`SSF_F_CHR7]);

    // RULE_09: overrun discards
    assign ovr_ev  = rx_take & serial_flags_reg[`SSF_B_RX_BUFFER_FULL];
    assign good_ev = rx_take & ~serial_flags_reg[`SSF_B_RX_BUFFER_FULL] & ~fer_raw & ~per_raw;

    // RULE_13: framing still loads
    // RULE_15: parity still loads
    // RULE_08: buffer held otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer <= `SSF_BUF_RST;
        end else if (rx_take && !serial_flags_reg[`SSF_B_RX_BUFFER_FULL]) begin
            rx_buffer <= rx_evt.data;
        end
    end

    assign rx_data = rx_buffer;

////////////////////////////////////////////////////////////////////////////////
// status flags

    always_comb begin
        sw_clr = 8'h00;
        for (int b = `SSF_B_HWFLAG_LO; b < 8; b++) begin
            // RULE_01: zero write after read
            sw_clr[b] = wr_status & ~pwdata[b] & read_seen[b] & clr_mask[b];
        end
        set_v = 8'h00;
        clr_v = 8'h00;
        // RULE_04: empty setting
        set_v[`SSF_B_TX_BUFFER_EMPTY] = tx_load | ~tx_on;
        // RULE_05: empty clearing
        clr_v[`SSF_B_TX_BUFFER_EMPTY] = sw_clr[`SSF_B_TX_BUFFER_EMPTY] | dma_tx_write;
        // RULE_06: clean receive sets full
        set_v[`SSF_B_RX_BUFFER_FULL] = good_ev;
        // RULE_07: full clearing
        clr_v[`SSF_B_RX_BUFFER_FULL] = sw_clr[`SSF_B_RX_BUFFER_FULL] | dma_rx_read;
        set_v[`SSF_B_OVERRUN_FLAG] = ovr_ev;
        set_v[`SSF_B_FER]  = rx_take & ~serial_flags_reg[`SSF_B_RX_BUFFER_FULL] & fer_raw;
        set_v[`SSF_B_PER]  = rx_take & ~serial_flags_reg[`SSF_B_RX_BUFFER_FULL] & per_raw;
        clr_v[`SSF_B_OVERRUN_FLAG] = sw_clr[`SSF_B_OVERRUN_FLAG];
        clr_v[`SSF_B_FER]  = sw_clr[`SSF_B_FER];
        clr_v[`SSF_B_PER]  = sw_clr[`SSF_B_PER];
        // RULE_17: done setting
        set_v[`SSF_B_TX_DONE] = ~tx_on | (tx_last_bit & serial_flags_reg[`SSF_B_TX_BUFFER_EMPTY]);
        // RULE_18: done follows empty clear
        clr_v[`SSF_B_TX_DONE] = sw_clr[`SSF_B_TX_BUFFER_EMPTY] | dma_tx_write;

        next_flags = serial_flags_reg;
        // RULE_16: receiver off touches nothing here
        for (int b = `SSF_B_HWFLAG_LO; b < 8; b++) begin
            // a set in the same cycle as a clear wins
            next_flags[b] = set_v[b] | (serial_flags_reg[b] & ~clr_v[b]);
        end
        // RULE_19: address bit capture
        if (rx_take && !serial_flags_reg[`SSF_B_RX_BUFFER_FULL] && async_mode &&
            serial_format_reg[`SSF_F_MP]) begin
            next_flags[`SSF_B_RXADDR] = rx_evt.mp;
        end
        // RULE_03: read-only bits skip the write
        if (wr_status) begin
            next_flags[`SSF_B_TXADDR] = pwdata[`SSF_B_TXADDR];
        end
    end

    // RULE_02: reset and standby value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_flags_reg <= `SSF_STATUS_RST;
        end else if (standby) begin
            serial_flags_reg <= `SSF_STATUS_RST;
        end else begin
            serial_flags_reg <= next_flags;
        end
    end

    // RULE_23: read-as-one record
    always_comb begin
        next_seen = 8'h00;
        for (int b = `SSF_B_HWFLAG_LO; b < 8; b++) begin
            if (set_v[b] || !next_flags[b]) begin
                next_seen[b] = 1'b0;
            end else if (rd_status && prdata[b]) begin
                next_seen[b] = 1'b1;
            end else begin
                next_seen[b] = read_seen[b];
            end
        end
        next_seen = next_seen & `SSF_CLR_MASK;
    end

    // the transmit-done bit shares the empty flag's record, it has none of its own
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_seen <= 8'h00;
        end else if (standby) begin
            read_seen <= 8'h00;
        end else begin
            read_seen <= next_seen;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// transmit offer and interrupt requests

    always_comb begin
        // RULE_10: sync errors stop tx
        tx_req.go    = tx_on & ~serial_flags_reg[`SSF_B_TX_BUFFER_EMPTY] & ~(~async_mode & err_any);
        tx_req.data  = tx_buffer;
        // RULE_20: address bit only in async mp
        tx_req.mp_en = async_mode & serial_format_reg[`SSF_F_MP];
        tx_req.mp    = tx_req.mp_en & serial_flags_reg[`SSF_B_TXADDR];
    end

    // RULE_21: receive requests
    assign rx_full_irq   = serial_ctrl_reg[`SSF_C_RXIRQ_ON] & serial_flags_reg[`SSF_B_RX_BUFFER_FULL];
    assign rx_error_irq  = serial_ctrl_reg[`SSF_C_RXIRQ_ON] & err_any;
    // RULE_22: transmit-end request
    assign tx_finish_irq = serial_ctrl_reg[`SSF_C_TXFIN_ON] & serial_flags_reg[`SSF_B_TX_DONE];

////////////////////////////////////////////////////////////////////////////////
// assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_W1_NO_EFFECT: assert property ( // RULE_01
        wr_status && pwdata[`SSF_B_RX_BUFFER_FULL] && !serial_flags_reg[`SSF_B_RX_BUFFER_FULL] && !good_ev
        |=> !serial_flags_reg[`SSF_B_RX_BUFFER_FULL])
        else $error("writing one set the receive-full flag");

    AST_CLR_NEEDS_READ: assert property ( // RULE_23
        wr_status && !pwdata[`SSF_B_FER] && serial_flags_reg[`SSF_B_FER] &&
        !read_seen[`SSF_B_FER] && !standby
        |=> serial_flags_reg[`SSF_B_FER])
        else $error("framing flag cleared without a prior read as one");

    AST_READ_THEN_CLEAR: assert property ( // RULE_01
        rd_status && prdata[`SSF_B_FER] && serial_flags_reg[`SSF_B_FER] && !set_v[`SSF_B_FER]
        ##[2:8] (wr_status && !pwdata[`SSF_B_FER] && !set_v[`SSF_B_FER] && !standby)
        |=> !serial_flags_reg[`SSF_B_FER])
        else $error("framing flag not cleared by read one then write zero");

    AST_STANDBY_VALUE: assert property ( // RULE_02
        standby |=> serial_flags_reg == `SSF_STATUS_RST)
        else $error("status not at reset value after standby");

    AST_TX_DONE_READ_ONLY: assert property ( // RULE_03
        wr_status && !serial_flags_reg[`SSF_B_TX_DONE] && !set_v[`SSF_B_TX_DONE] && !standby
        |=> !serial_flags_reg[`SSF_B_TX_DONE])
        else $error("cpu write changed transmit-done");

    AST_TX_BUFFER_EMPTY_ON_LOAD: assert property ( // RULE_04
        tx_load |=> serial_flags_reg[`SSF_B_TX_BUFFER_EMPTY])
        else $error("transmit-empty not set after shifter load");

    AST_DMA_CLEARS_TX: assert property ( // RULE_05
        dma_tx_write && tx_on && !tx_load && !tx_last_bit && !standby
        |=> !serial_flags_reg[`SSF_B_TX_BUFFER_EMPTY] && !serial_flags_reg[`SSF_B_TX_DONE])
        else $error("dma write left transmit flags set");

    AST_GOOD_RX: assert property ( // RULE_06
        good_ev && !standby
        |=> serial_flags_reg[`SSF_B_RX_BUFFER_FULL] && rx_buffer == $past(rx_evt.data))
        else $error("clean character did not reach buffer with full flag");

    AST_OVERRUN: assert property ( // RULE_09
        ovr_ev && !standby |=> serial_flags_reg[`SSF_B_OVERRUN_FLAG] && $stable(rx_buffer))
        else $error("overrun not flagged or buffer overwritten");

    AST_ERR_BLOCKS: assert property ( // RULE_10
        err_any |-> !rx_accept && !(tx_req.go && !async_mode))
        else $error("transfer allowed while an error flag is set");

    AST_FRAMING: assert property ( // RULE_13
        rx_take && !serial_flags_reg[`SSF_B_RX_BUFFER_FULL] && fer_raw && !standby
        |=> serial_flags_reg[`SSF_B_FER] && !serial_flags_reg[`SSF_B_RX_BUFFER_FULL] &&
            rx_buffer == $past(rx_evt.data))
        else $error("framing error handling wrong");

    AST_TX_IRQ: assert property ( // RULE_22
        tx_finish_irq == (serial_ctrl_reg[`SSF_C_TXFIN_ON] && serial_flags_reg[`SSF_B_TX_DONE]))
        else $error("transmit-end request does not follow its flag");

    COV_GOOD_RX:   cover property (good_ev);
    COV_OVERRUN:   cover property (ovr_ev);
    COV_SW_CLEAR:  cover property (rd_status ##[2:8] (wr_status && |sw_clr));
    COV_TX_END:    cover property (tx_last_bit && serial_flags_reg[`SSF_B_TX_BUFFER_EMPTY] && tx_on);

endmodule

// file: tb/serial_status_flags_bench.sv
/*
 * Self-checking bench of the serial status flag block: APB master, receive
 * events, DMA strobes and standby are driven here; the transmit shifter is
 * a partner model. Assumes pready comes in the access phase of each transfer.
 */
`include "ssf_regs.svh"

module serial_status_flags_bench
    import ssf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] st  = `SSF_OFS_STATUS;
    localparam logic [7:0] ctl = `SSF_OFS_CTRL;
    localparam logic [7:0] fmt = `SSF_OFS_FORMAT;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, standby;
    logic [7:0]  paddr, rx_data, dma_tx_data, load_wait, d1, d2;
    logic [31:0] pwdata, prdata;
    logic        tx_load, tx_last_bit, rx_accept, dma_tx_write, dma_rx_read, busy;
    logic        rx_full_irq, rx_error_irq, tx_finish_irq;
    ssf_tx_req_t tx_req;
    ssf_rx_evt_t rx_evt;
    logic [32:0] expq[$];
    logic [32:0] exp_next;
    int          failures, n_compared, cycles, seed;

    ssf_status dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby(standby), .tx_load(tx_load),
        .tx_last_bit(tx_last_bit), .tx_req(tx_req), .rx_evt(rx_evt),
        .rx_accept(rx_accept), .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data),
        .dma_rx_read(dma_rx_read), .rx_data(rx_data), .rx_full_irq(rx_full_irq),
        .rx_error_irq(rx_error_irq), .tx_finish_irq(tx_finish_irq)
    );

    ssf_tx_partner shifter (
        .pclk(pclk), .presetn(presetn), .tx_req(tx_req), .load_wait(load_wait),
        .tx_load(tx_load), .tx_last_bit(tx_last_bit), .busy(busy)
    );

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // the note goes in before the access edge that the monitor compares at
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, {1'b0, 24'h0, e});
    endtask

    // released fields show the inverse so stale data cannot pass
    task automatic rx_char(input logic [7:0] d, input logic p, input logic m,
                           input logic s);
        @(posedge pclk);
        rx_evt <= {1'b1, d, p, m, s};
        @(posedge pclk);
        rx_evt <= {1'b0, ~d, ~p, ~m, ~s};
        @(negedge pclk);
    endtask

    task automatic dma_write(input logic [7:0] d);
        @(posedge pclk);
        dma_tx_write <= 1'b1;
        dma_tx_data <= d;
        @(posedge pclk);
        dma_tx_write <= 1'b0;
        dma_tx_data <= ~d;
        @(negedge pclk);
    endtask

    task automatic wait_idle();
        @(posedge pclk);
        while (busy !== 1'b0) @(posedge pclk);
        @(negedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            exp_next = (expq.size() > 0) ? expq.pop_front() : 'x;
            check({pslverr, pwrite ? 32'h0 : prdata}, exp_next);
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hc892bd6e;
        {presetn, psel, penable, pwrite, standby, dma_tx_write, dma_rx_read} = '0;
        {paddr, pwdata, dma_tx_data} = '0;
        rx_evt = '0;
        load_wait = 8'd40;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(st, 8'h84);
        apb(1'b0, 8'h14, 8'h00, {1'b1, 32'h0});
        wr(st, 8'hff);
        rd(st, 8'h85);
        wr(st, 8'h00);
        rd(st, 8'h84);
        wr(ctl, 8'h0f);
        wr(fmt, 8'h08);
        rd(st, 8'h84);
        wr(st, 8'h79);
        rd(st, 8'h01);
        @(negedge pclk);
        check({tx_req.go, tx_req.mp_en, tx_req.mp}, 3'b111);
        wait_idle();
        check(tx_finish_irq, 1'b1);
        rd(st, 8'h85);
        d1 = 8'($random(seed));
        dma_write(d1);
        check({tx_req.go, tx_req.data}, {1'b1, d1});
        rd(st, 8'h01);
        wr(ctl, 8'h0e);
        rd(st, 8'h85);
        wr(ctl, 8'h0f);
        wr(fmt, 8'h09);
        @(negedge pclk);
        check(tx_req.mp_en, 1'b0);
        wr(fmt, 8'h08);
        wait_idle();
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        rx_char(d1, 1'b0, 1'b1, 1'b1);
        check({rx_data, rx_full_irq}, {d1, 1'b1});
        rd(st, 8'hc7);
        rx_char(d2, 1'b0, 1'b0, 1'b1);
        check({rx_data, rx_accept, rx_error_irq}, {d1, 2'b01});
        rx_char(~d1, 1'b0, 1'b0, 1'b0);
        check(rx_data, d1);
        rd(st, 8'he7);
        wr(ctl, 8'h0d);
        rd(st, 8'he7);
        wr(ctl, 8'h0f);
        wr(st, 8'hdf);
        rd(st, 8'hc7);
        @(posedge pclk);
        dma_rx_read <= 1'b1;
        @(posedge pclk);
        dma_rx_read <= 1'b0;
        rd(st, 8'h87);
        d2 = 8'($random(seed));
        rx_char(d2, 1'b0, 1'b0, 1'b0);
        check({rx_data, rx_full_irq, rx_error_irq}, {d2, 2'b01});
        wr(st, 8'hef);
        rd(st, 8'h95);
        wr(st, 8'hef);
        rd(st, 8'h85);
        wr(fmt, 8'h02);
        rx_char(8'h01, 1'b0, 1'b0, 1'b1);
        check({rx_data, rx_full_irq}, {8'h01, 1'b0});
        rd(st, 8'h8d);
        wr(st, 8'hf7);
        wr(fmt, 8'h06);
        rx_char(8'h01, 1'b0, 1'b0, 1'b1);
        rd(st, 8'hc5);
        @(posedge pclk);
        standby <= 1'b1;
        @(posedge pclk);
        standby <= 1'b0;
        rd(st, 8'h84);
        repeat (2) @(posedge pclk);
        complete_run();
    end
endmodule

// file: tb/ssf_tx_partner.sv
/*
 * Transmit shifter model for the serial status flag bench: takes the
 * buffer when the block offers it, then sends the character out.
 * Assumes the same pclk as the block; load_wait sets how slowly it answers.
 */
module ssf_tx_partner
    import ssf_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // offer from the block
    input  wire ssf_tx_req_t tx_req,
    input  wire logic [7:0]  load_wait,
    // shifter events
    output logic             tx_load,
    output logic             tx_last_bit,
    output logic             busy
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        tx_load = 1'b0;
        tx_last_bit = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (presetn === 1'b1 && tx_req.go === 1'b1) begin
                busy <= 1'b1;
                repeat (load_wait) @(posedge pclk);
                if (tx_req.go === 1'b1) begin
                    tx_load <= 1'b1;
                    @(posedge pclk);
                    tx_load <= 1'b0;
                    // nine bit times before the last one
                    repeat (9) @(posedge pclk);
                    tx_last_bit <= 1'b1;
                    @(posedge pclk);
                    tx_last_bit <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
